// ==== rcs_cause_detect.sv ====
/*
 * Combinational priority decode of the synchronised reset sources.
 * Assumes all inputs are already in the clock_i domain.
 */
`timescale 1ns/1ps
`default_nettype none
module rcs_cause_detect
    import rcs_pkg::*;
(
    input wire logic pin_reset_i,
    input wire logic watchdog_expired_i,
    input wire logic watchdog_enable_i,
    input wire logic stop_exec_i,
    input wire logic stop_enable_i,
    input wire logic bg_entry_exec_i,
    input wire logic debug_mode_enable_i,
    input wire logic illegal_opcode_i,
    input wire logic illegal_address_i,
    input wire logic low_voltage_i,
    input wire logic low_voltage_reset_enable_i,
    input wire logic force_i,
    rcs_cause_if.source cause_o
);

    logic watchdog_hit;
    logic opcode_hit;

    always_comb
    begin
        watchdog_hit = watchdog_expired_i & watchdog_enable_i;
        opcode_hit = illegal_opcode_i
            | (stop_exec_i & ~stop_enable_i)
            | (bg_entry_exec_i & ~debug_mode_enable_i);
        cause_o.flags = RCS_ZERO_BYTE;
        cause_o.flags[RCS_BIT_PIN] = pin_reset_i;
        cause_o.flags[RCS_BIT_WATCHDOG] = watchdog_hit;
        cause_o.flags[RCS_BIT_ILLEGAL_OPCODE] = opcode_hit;
        cause_o.flags[RCS_BIT_ILLEGAL_ADDRESS] = illegal_address_i;
        cause_o.request = 1'b1;
        if (low_voltage_i && low_voltage_reset_enable_i)
        begin
            cause_o.cause = RCS_CAUSE_LOW_VOLTAGE;
        end
        else if (pin_reset_i || watchdog_hit || opcode_hit || illegal_address_i)
        begin
            cause_o.cause = RCS_CAUSE_OTHER;
        end
        else if (force_i)
        begin
            cause_o.cause = RCS_CAUSE_FORCED;
        end
        else
        begin
            cause_o.cause = RCS_CAUSE_NONE;
            cause_o.request = 1'b0;
        end
    end

endmodule : rcs_cause_detect
`default_nettype wire

// ==== rcs_cause_if.sv ====
/*
 * Interface carrying the decoded reset request from the cause detector to the top.
 * Assumes both ends run on clock_i.
 */
`timescale 1ns/1ps
`default_nettype none
interface rcs_cause_if;
    import rcs_pkg::*;
    logic request;
    rcs_cause_t cause;
    logic [7:0] flags;
    modport source (output request, output cause, output flags);
    modport sink (input request, input cause, input flags);
endinterface : rcs_cause_if
`default_nettype wire

// ==== rcs_debug_host.sv ====
/* Model of the external debug host that forces a reset.
   Assumes the bench muxes its bus onto the block while write_o is high. */
`timescale 1ns/1ps
`default_nettype none
module rcs_debug_host
    import rcs_pkg::*;
(
    input wire logic clock_i,
    output logic write_o,
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o,
    output logic mode_o
);
    // ------------------------------------------------------------
    // Force reset write
    // ------------------------------------------------------------
    initial
    begin
        write_o = 1'h0;
        addr_o = 4'h0;
        wdata_o = 8'h00;
        mode_o = 1'h1;
    end
    task force_reset();
        @(negedge clock_i);
        write_o = 1'h1;
        addr_o = RCS_ADDR_FORCE;
        wdata_o = 8'h01;
        @(negedge clock_i);
        write_o = 1'h0;
        mode_o = 1'h1;
        wdata_o = ~wdata_o;
    endtask : force_reset
endmodule : rcs_debug_host
`default_nettype wire

// ==== rcs_pkg.sv ====
/*
 * Package for the reset cause status block: register addresses, field positions,
 * reset values and the reset-cause enumeration.
 * Assumes an 8-bit register port with one write strobe qualified by a debug-access input.
 */
package rcs_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] RCS_ADDR_STATUS = 4'h0;
    localparam logic [3:0] RCS_ADDR_FORCE = 4'h1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RCS_BIT_POWER_ON = 7;
    localparam int RCS_BIT_PIN = 6;
    localparam int RCS_BIT_WATCHDOG = 5;
    localparam int RCS_BIT_ILLEGAL_OPCODE = 4;
    localparam int RCS_BIT_ILLEGAL_ADDRESS = 3;
    localparam int RCS_BIT_LOW_VOLTAGE = 1;
    localparam int RCS_BIT_FORCE_RESET = 0;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [7:0] RCS_STATUS_POR_VALUE = 8'h82;
    localparam logic [7:0] RCS_STATUS_IMPL_MASK = 8'hFA;
    localparam logic [7:0] RCS_FORCE_READ_VALUE = 8'h00;
    localparam logic [7:0] RCS_ZERO_BYTE = 8'h00;
    localparam logic [3:0] RCS_RESET_HOLD_CYCLES = 4'h4;

    typedef enum logic [2:0] {
        RCS_CAUSE_NONE,
        RCS_CAUSE_LOW_VOLTAGE,
        RCS_CAUSE_OTHER,
        RCS_CAUSE_FORCED
    } rcs_cause_t;

endpackage : rcs_pkg

// ==== rcs_reset_cause_status.sv ====
/*
 * Top of the reset cause status block: status register, debug force-reset register,
 * watchdog service strobe and system reset request.
 * Assumes power-on is rst_n_i, pins and event inputs come from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Read-only status register records which source caused the latest reset.
// - A debug forced reset leaves every status flag cleared.
// - Any write to the status address restarts the watchdog, flags unchanged.
// - Power-on sets bit 7 and bit 1, clears all others.
// - Enabled low-voltage reset sets bit 1, keeps bit 7, clears others.
// - Other resets clear bits 7 and 1, set active causes, clear rest.
// - Low level on reset terminal sets bit 6.
// - Watchdog timeout sets bit 5, blocked while watchdog enable is zero.
// - Illegal opcode resets and sets bit 4.
// - Stop with stop enable zero counts as illegal opcode.
// - Background entry with debug enable zero counts as illegal opcode.
// - Access to unimplemented address resets and sets bit 3.
// - Force-reset register is write-only and reads zero.
// - User program writes to force-reset register are ignored.
// - Debug write of one to bit 0 forces a full reset.
module rcs_reset_cause_status
    import rcs_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_debug_i,
    input wire logic reg_read_i,
    input wire logic reset_pin_n_i,
    input wire logic watchdog_expired_i,
    input wire logic watchdog_enable_i,
    input wire logic stop_exec_i,
    input wire logic stop_enable_i,
    input wire logic bg_entry_exec_i,
    input wire logic debug_mode_enable_i,
    input wire logic illegal_opcode_i,
    input wire logic illegal_address_i,
    input wire logic low_voltage_i,
    input wire logic low_voltage_reset_enable_i,
    output logic [7:0] reg_rdata_o,
    output logic watchdog_service_o,
    output logic system_reset_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] sync_raw;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;

    assign sync_raw = {~reset_pin_n_i, watchdog_expired_i, watchdog_enable_i, stop_exec_i, stop_enable_i,
                       bg_entry_exec_i, debug_mode_enable_i, illegal_opcode_i, illegal_address_i, low_voltage_i};

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= sync_raw;
            sync_b <= sync_a;
        end
    end

    logic lvre_a;
    logic lvre_b;
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lvre_a <= 1'b0;
            lvre_b <= 1'b0;
        end
        else
        begin
            lvre_a <= low_voltage_reset_enable_i;
            lvre_b <= lvre_a;
        end
    end

    // ------------------------------------------------------------
    // Cause decode
    // ------------------------------------------------------------
    rcs_cause_if cause_bus ();
    logic force_pending;

    rcs_cause_detect u_detect (
        .pin_reset_i(sync_b[9]),
        .watchdog_expired_i(sync_b[8]),
        .watchdog_enable_i(sync_b[7]),
        .stop_exec_i(sync_b[6]),
        .stop_enable_i(sync_b[5]),
        .bg_entry_exec_i(sync_b[4]),
        .debug_mode_enable_i(sync_b[3]),
        .illegal_opcode_i(sync_b[2]),
        .illegal_address_i(sync_b[1]),
        .low_voltage_i(sync_b[0]),
        .low_voltage_reset_enable_i(lvre_b),
        .force_i(force_pending),
        .cause_o(cause_bus.source)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] next_status;
    logic next_force_pending;
    logic [3:0] hold_count;
    logic [3:0] next_hold_count;
    logic [7:0] next_rdata;
    logic next_service;
    logic next_system_reset;
    logic status_write;
    logic force_write;

    always_comb
    begin
        status_write = reg_write_i && (reg_addr_i == RCS_ADDR_STATUS);
        force_write = reg_write_i && reg_debug_i && (reg_addr_i == RCS_ADDR_FORCE);
        next_status = status;
        next_force_pending = force_pending;
        next_hold_count = hold_count;
        next_service = status_write;
        next_system_reset = 1'b0;
        next_rdata = RCS_ZERO_BYTE;
        if (force_write && reg_wdata_i[RCS_BIT_FORCE_RESET])
        begin
            next_force_pending = 1'b1;
        end
        if (hold_count != 4'h0)
        begin
            next_hold_count = hold_count - 4'h1;
            next_system_reset = 1'b1;
        end
        else if (cause_bus.request)
        begin
            next_hold_count = RCS_RESET_HOLD_CYCLES;
            next_system_reset = 1'b1;
            next_force_pending = 1'b0;
            case (cause_bus.cause)
                RCS_CAUSE_LOW_VOLTAGE:
                begin
                    next_status = RCS_ZERO_BYTE;
                    next_status[RCS_BIT_POWER_ON] = status[RCS_BIT_POWER_ON];
                    next_status[RCS_BIT_LOW_VOLTAGE] = 1'b1;
                end
                RCS_CAUSE_OTHER:
                begin
                    next_status = cause_bus.flags & RCS_STATUS_IMPL_MASK;
                end
                RCS_CAUSE_FORCED:
                begin
                    next_status = RCS_ZERO_BYTE;
                end
                default:
                begin
                    next_status = status;
                end
            endcase
        end
        if (reg_read_i)
        begin
            if (reg_addr_i == RCS_ADDR_STATUS)
            begin
                next_rdata = status & RCS_STATUS_IMPL_MASK;
            end
            else
            begin
                next_rdata = RCS_FORCE_READ_VALUE;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            status <= RCS_STATUS_POR_VALUE;
            force_pending <= 1'b0;
            hold_count <= 4'h0;
            reg_rdata_o <= RCS_ZERO_BYTE;
            watchdog_service_o <= 1'b0;
            system_reset_o <= 1'b0;
        end
        else
        begin
            status <= next_status;
            force_pending <= next_force_pending;
            hold_count <= next_hold_count;
            reg_rdata_o <= next_rdata;
            watchdog_service_o <= next_service;
            system_reset_o <= next_system_reset;
        end
    end

endmodule : rcs_reset_cause_status
`default_nettype wire

// ==== rcs_reset_cause_status_bench.sv ====
/* Self-checking bench for the reset cause status block.
   Assumes the debug host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_status_bench
    import rcs_pkg::*;
;
    logic clock_i, rst_n_i, w, rd, h_w, svc, sr, sr_seen;
    logic [3:0] a, h_a;
    logic [7:0] d, h_d, v, prev;
    logic [10:0] src;
    logic [31:0] seed;
    int n_mismatch, compares;
    logic [10:0] cases [12] = '{11'h003, 11'h400, 11'h300, 11'h200, 11'h008, 11'h080,
        11'h0C0, 11'h020, 11'h030, 11'h004, 11'h002, 11'h003};
    rcs_reset_cause_status u_rcs_reset_cause_status (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reg_addr_i(h_w ? h_a : a), .reg_wdata_i(h_w ? h_d : d), .reg_write_i(w | h_w),
        .reg_debug_i(h_w), .reg_read_i(rd), .reset_pin_n_i(!src[10]),
        .watchdog_expired_i(src[9]), .watchdog_enable_i(src[8]), .stop_exec_i(src[7]),
        .stop_enable_i(src[6]), .bg_entry_exec_i(src[5]), .debug_mode_enable_i(src[4]),
        .illegal_opcode_i(src[3]), .illegal_address_i(src[2]), .low_voltage_i(src[1]),
        .low_voltage_reset_enable_i(src[0]), .reg_rdata_o(v), .watchdog_service_o(svc),
        .system_reset_o(sr));
    rcs_debug_host u_rcs_debug_host (.clock_i(clock_i), .write_o(h_w), .addr_o(h_a),
        .wdata_o(h_d), .mode_o());
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function logic [8:0] expect_st(input logic [10:0] s, input logic [7:0] p);
        logic [7:0] e;
        e = {1'h0, s[10], s[9] & s[8], s[3] | (s[7] & !s[6]) | (s[5] & !s[4]), s[2], 3'h0};
        if (s[1] && s[0])
            return {1'h1, (p & 8'h80) | 8'h02};
        return {e != 8'h00, (e != 8'h00) ? e : p};
    endfunction : expect_st
    task finish_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [3:0] ad, input logic [7:0] dt);
        @(negedge clock_i);
        w = 1'h1;
        a = ad;
        d = dt;
        @(negedge clock_i);
        w = 1'h0;
        d = ~dt;
        chk("service", {7'h00, svc}, {7'h00, ad == RCS_ADDR_STATUS});
    endtask : wr
    task rd_chk(input logic [3:0] ad, input logic [7:0] ex, input string nm);
        @(negedge clock_i);
        rd = 1'h1;
        a = ad;
        @(negedge clock_i);
        rd = 1'h0;
        chk(nm, v, ex);
    endtask : rd_chk
    task wait_sr(input logic lvl);
        int k;
        for (k = 0; k < 40 && sr !== lvl; k++)
            @(negedge clock_i);
        if (k == 40)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_sr
    task run(input logic [10:0] s);
        logic [8:0] ex;
        ex = expect_st(s, prev);
        @(negedge clock_i);
        src = s;
        sr_seen = 1'h0;
        for (int k = 0; k < 12 && !sr_seen; k++)
        begin
            @(negedge clock_i);
            sr_seen = sr === 1'h1;
        end
        chk("reset", {7'h00, sr_seen}, {7'h00, ex[8]});
        src = 11'h000;
        if (sr_seen)
            wait_sr(1'h0);
        repeat (3) @(negedge clock_i);
        rd_chk(RCS_ADDR_STATUS, ex[7:0], "status");
        prev = ex[7:0];
    endtask : run
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        clock_i = 1'h0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial
    begin
        {rst_n_i, w, rd, a, d, src, n_mismatch, compares} = '0;
        seed = 32'hA514D833;
        prev = RCS_STATUS_POR_VALUE;
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'h1;
        rd_chk(RCS_ADDR_STATUS, 8'h82, "por");
        rd_chk(RCS_ADDR_FORCE, 8'h00, "force");
        rd_chk(4'hF, 8'h00, "unmapped");
        foreach (cases[i]) run(cases[i]);
        wr(RCS_ADDR_FORCE, 8'h01);
        run(11'h000);
        u_rcs_debug_host.force_reset();
        wait_sr(1'h1);
        wait_sr(1'h0);
        rd_chk(RCS_ADDR_STATUS, 8'h00, "forced");
        prev = 8'h00;
        repeat (20)
        begin
            seed = xs(seed);
            wr(RCS_ADDR_STATUS, seed[31:24]);
            run(seed[10:0]);
        end
        finish_test();
    end
endmodule : rcs_reset_cause_status_bench
`default_nettype wire

// ==== rcs_reset_cause_status_chk.sv ====
/* Assertions for the reset cause status block.
   Sees only the top ports; bound to the top below. */
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_status_chk
    import rcs_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_debug_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic watchdog_service_o,
    input wire logic system_reset_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence status_wr_s;
        reg_write_i && reg_addr_i == RCS_ADDR_STATUS;
    endsequence
    sequence force_wr_s;
        reg_write_i && reg_debug_i && reg_addr_i == RCS_ADDR_FORCE && reg_wdata_i[0];
    endsequence
    service_pulse_a: assert property (status_wr_s |=> watchdog_service_o)
        else $error("no service pulse after status write");
    service_cause_a: assert property (watchdog_service_o |-> $past(reg_write_i) && $past(reg_addr_i) == 4'h0)
        else $error("service pulse without status write");
    service_once_a: assert property (watchdog_service_o && !reg_write_i |=> !watchdog_service_o)
        else $error("service pulse too long");
    force_read_a: assert property (reg_read_i && reg_addr_i == RCS_ADDR_FORCE |=> reg_rdata_o == 8'h00)
        else $error("force register read not zero");
    status_res_a: assert property (reg_read_i && reg_addr_i == 4'h0 |=> (reg_rdata_o & 8'h05) == 8'h00)
        else $error("reserved status bits set");
    idle_rdata_a: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
        else $error("read data without read");
    force_reset_a: assert property (force_wr_s |-> ##2 system_reset_o)
        else $error("forced reset missing");
    reset_hold_a: assert property ($rose(system_reset_o) |-> system_reset_o [*5])
        else $error("reset request too short");
endmodule : rcs_reset_cause_status_chk
bind rcs_reset_cause_status rcs_reset_cause_status_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_debug_i(reg_debug_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .watchdog_service_o(watchdog_service_o),
    .system_reset_o(system_reset_o));
`default_nettype wire
